// >>> pkg/bst_pkg.sv
`default_nettype none
package bst_pkg;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  localparam int          IR_WIDTH      = 3;
  localparam logic [2:0]  IR_EXTEST     = 3'h0;
  localparam logic [2:0]  IR_IDCODE     = 3'h1;
  localparam logic [2:0]  IR_SAMPLE     = 3'h2;
  localparam logic [2:0]  IR_CLAMP      = 3'h3;
  localparam logic [2:0]  IR_HIGHZ      = 3'h4;
  localparam logic [2:0]  IR_BYPASS     = 3'h7;
  localparam logic [2:0]  IR_CAPTURE    = 3'h1;
  localparam logic [2:0]  IR_RESET_VAL  = IR_IDCODE;

  // ---------------------------------------------------------------
  // Identification register layout
  // ---------------------------------------------------------------
  localparam int          ID_WIDTH      = 32;
  localparam int          ID_MFR_LSB    = 1;
  localparam int          ID_PART_LSB   = 12;
  localparam int          ID_VER_LSB    = 28;
  localparam int          BSR_LEN_DEF   = 46;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_state_e;

endpackage : bst_pkg
`default_nettype wire

// >>> logic/bst_sync.sv
`default_nettype none
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : bst_sync
`default_nettype wire

// >>> logic/bst_tap.sv
`default_nettype none
module bst_tap
  import bst_pkg::*;
#(
  parameter int          BSR_LEN  = BSR_LEN_DEF,
  parameter logic [10:0] MFR_CODE = 11'h001, // Arbitrary value.
  parameter logic [15:0] PART_ID  = 16'h0001, // Arbitrary value.
  parameter logic [3:0]  VERSION  = 4'h0      // Arbitrary value.
) (
  input  wire logic               CLK_SYS,
  input  wire logic               RST_N,
  input  wire logic               TEST_PORT_RESET_N,
  input  wire logic               TEST_PORT_CLOCK,
  input  wire logic               TEST_PORT_MODE_SELECT,
  input  wire logic               TEST_PORT_SERIAL_IN,
  output var  logic               TEST_PORT_SERIAL_OUT,
  output var  logic               TEST_PORT_SERIAL_OE,
  input  wire logic [BSR_LEN-1:0] PIN_SAMPLE,
  input  wire logic [BSR_LEN-1:0] CORE_OUT,
  output var  logic [BSR_LEN-1:0] PIN_OUT,
  output var  logic               PIN_OUT_EN,
  output var  logic [IR_WIDTH-1:0] CUR_INSTR,
  output var  logic [3:0]         TAP_STATE
);

  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_s;
  logic       tck_d_reg;
  logic       trst_n_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       rise;
  logic       fall;

  bst_sync #(.WIDTH(4)) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .d     ({TEST_PORT_RESET_N, TEST_PORT_CLOCK, TEST_PORT_MODE_SELECT,
             TEST_PORT_SERIAL_IN}),
    .q     (pin_s)
  );

  assign trst_n_s = pin_s[3];
  assign tck_s    = pin_s[2];
  assign tms_s    = pin_s[1];
  assign tdi_s    = pin_s[0];

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) tck_d_reg <= 1'b0;
    else        tck_d_reg <= tck_s;
  end

  // Mode select and serial in are sampled at the same synchronised edge as the clock.
  assign rise = tck_s & ~tck_d_reg;
  assign fall = ~tck_s & tck_d_reg;

  // ---------------------------------------------------------------
  // Controller state machine
  // ---------------------------------------------------------------
  bst_state_e state_reg;
  bst_state_e state_next;
  logic       tap_rst;

  // Test reset acts through the synchroniser; this trades two cycles of latency
  // for a single clock domain, still independent of the test clock.
  assign tap_rst = !RST_N || !trst_n_s;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET:    state_next = tms_s ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_next = tms_s ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_next = tms_s ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_next = tms_s ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (tap_rst)   state_reg <= ST_RESET;
    else if (rise) state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  logic [IR_WIDTH-1:0] ir_shift_reg;
  logic [IR_WIDTH-1:0] ir_reg;

  always_ff @(posedge CLK_SYS) begin
    if (tap_rst) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (rise) begin
      if (state_reg == ST_CAP_IR) ir_shift_reg <= IR_CAPTURE;
      else if (state_reg == ST_SHIFT_IR)
        ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (tap_rst)                                ir_reg <= IR_RESET_VAL;
    else if (state_reg == ST_RESET)             ir_reg <= IR_RESET_VAL;
    else if (fall && state_reg == ST_UPD_IR)    ir_reg <= ir_shift_reg;
  end

  // ---------------------------------------------------------------
  // Data registers
  // ---------------------------------------------------------------
  logic                bypass_reg;
  logic [ID_WIDTH-1:0] id_reg;
  logic [BSR_LEN-1:0]  bsr_shift_reg;
  logic [BSR_LEN-1:0]  bsr_latch_reg;
  logic [ID_WIDTH-1:0] id_value;
  logic                sel_bsr;
  logic                sel_id;

  assign id_value = {VERSION, PART_ID, MFR_CODE, 1'b1};

  // Unlisted codes fall back to bypass, as the standard requires.
  assign sel_bsr = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE);
  assign sel_id  = (ir_reg == IR_IDCODE);

  // Only the selected register moves; all others hold in every state.
  always_ff @(posedge CLK_SYS) begin
    if (tap_rst) begin
      bypass_reg    <= 1'b0;
      id_reg        <= '0;
      bsr_shift_reg <= '0;
    end else if (rise) begin
      if (state_reg == ST_CAP_DR) begin
        if (sel_bsr)     bsr_shift_reg <= PIN_SAMPLE;
        else if (sel_id) id_reg        <= id_value;
        else             bypass_reg    <= 1'b0;
      end else if (state_reg == ST_SHIFT_DR) begin
        if (sel_bsr)     bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
        else if (sel_id) id_reg        <= {tdi_s, id_reg[ID_WIDTH-1:1]};
        else             bypass_reg    <= tdi_s;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (tap_rst) bsr_latch_reg <= '0;
    else if (fall && state_reg == ST_UPD_DR && sel_bsr)
      bsr_latch_reg <= bsr_shift_reg;
  end

  // ---------------------------------------------------------------
  // Serial output, changed on the falling test clock edge
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (tap_rst) begin
      TEST_PORT_SERIAL_OUT <= 1'b0;
      TEST_PORT_SERIAL_OE  <= 1'b0;
    end else if (fall) begin
      TEST_PORT_SERIAL_OE <= (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);
      if (state_reg == ST_SHIFT_IR) TEST_PORT_SERIAL_OUT <= ir_shift_reg[0];
      else if (sel_bsr)             TEST_PORT_SERIAL_OUT <= bsr_shift_reg[0];
      else if (sel_id)              TEST_PORT_SERIAL_OUT <= id_reg[0];
      else                          TEST_PORT_SERIAL_OUT <= bypass_reg;
    end
  end

  // ---------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PIN_OUT    <= '0;
      PIN_OUT_EN <= 1'b1;
      CUR_INSTR  <= IR_RESET_VAL;
      TAP_STATE  <= 4'h0;
    end else begin
      // Normal system logic drives the pins unless extest or clamp is current.
      PIN_OUT    <= (ir_reg == IR_EXTEST || ir_reg == IR_CLAMP) ? bsr_latch_reg
                                                                : CORE_OUT;
      PIN_OUT_EN <= (ir_reg != IR_HIGHZ);
      CUR_INSTR  <= ir_reg;
      TAP_STATE  <= state_reg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Transition checks look one cycle after the detected rise, when the state
  // register has moved; the mode select level of the rise is then the past value.
  chk_trst_state: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !trst_n_s |=> state_reg == ST_RESET && ir_reg == IR_IDCODE)
    else $error("test reset did not force reset state");
  chk_no_edge_hold: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    !rise |=> $stable(state_reg))
    else $error("state moved without a test clock rise");
  chk_reset_exit: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_RESET |=> state_reg == ($past(tms_s) ? ST_RESET : ST_IDLE))
    else $error("test-logic-reset transition wrong");
  chk_idle_exit: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_IDLE |=> state_reg == ($past(tms_s) ? ST_SEL_DR : ST_IDLE))
    else $error("run-test-idle transition wrong");
  chk_sel_dr: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_SEL_DR |=> state_reg == ($past(tms_s) ? ST_SEL_IR : ST_CAP_DR))
    else $error("select-DR transition wrong");
  chk_cap_dr_next: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_CAP_DR
      |=> state_reg == ($past(tms_s) ? ST_EXIT1_DR : ST_SHIFT_DR))
    else $error("capture-DR transition wrong");
  chk_exit1_dr: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_EXIT1_DR
      |=> state_reg == ($past(tms_s) ? ST_UPD_DR : ST_PAUSE_DR))
    else $error("exit1-DR transition wrong");
  chk_pause_dr: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_PAUSE_DR
      |=> state_reg == ($past(tms_s) ? ST_EXIT2_DR : ST_PAUSE_DR))
    else $error("pause-DR transition wrong");
  chk_exit2_dr: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_EXIT2_DR
      |=> state_reg == ($past(tms_s) ? ST_UPD_DR : ST_SHIFT_DR))
    else $error("exit2-DR transition wrong");
  chk_sel_ir: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_SEL_IR |=> state_reg == ($past(tms_s) ? ST_RESET : ST_CAP_IR))
    else $error("select-IR transition wrong");
  chk_exit1_ir: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_EXIT1_IR
      |=> state_reg == ($past(tms_s) ? ST_UPD_IR : ST_PAUSE_IR))
    else $error("exit1-IR transition wrong");
  chk_pause_ir: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_PAUSE_IR
      |=> state_reg == ($past(tms_s) ? ST_EXIT2_IR : ST_PAUSE_IR))
    else $error("pause-IR transition wrong");
  chk_exit2_ir: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_EXIT2_IR
      |=> state_reg == ($past(tms_s) ? ST_UPD_IR : ST_SHIFT_IR))
    else $error("exit2-IR transition wrong");
  chk_upd_ir_next: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_UPD_IR |=> state_reg == ($past(tms_s) ? ST_SEL_DR : ST_IDLE))
    else $error("update-IR transition wrong");
  chk_cap_ir: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_CAP_IR |=> ir_shift_reg[1:0] == 2'b01)
    else $error("capture-IR pattern wrong");
  chk_ir_update: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    fall && state_reg == ST_UPD_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not latched on update");
  chk_ir_hold: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    state_reg == ST_SHIFT_IR |=> $stable(ir_reg))
    else $error("instruction changed during shift");
  chk_idle_hold: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    state_reg == ST_IDLE
      |=> $stable(id_reg) && $stable(ir_reg) && $stable(bsr_shift_reg) && $stable(bypass_reg))
    else $error("registers changed in idle");
  chk_id_capture: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_CAP_DR && sel_id |=> id_reg == id_value && id_reg[0])
    else $error("identification not captured");
  chk_bypass_shift: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    rise && state_reg == ST_SHIFT_DR && !sel_bsr && !sel_id |=> bypass_reg == $past(tdi_s))
    else $error("bypass stage did not take serial in");
  chk_shift_oe: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    fall && state_reg == ST_SHIFT_DR |=> TEST_PORT_SERIAL_OE)
    else $error("serial out not driven while shifting");
  chk_bsr_latch: assert property (
    @(posedge CLK_SYS) disable iff (tap_rst)
    state_reg == ST_SHIFT_DR |=> $stable(bsr_latch_reg))
    else $error("boundary latch changed while shifting");
  chk_clamp_pins: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ir_reg == IR_CLAMP |=> PIN_OUT == $past(bsr_latch_reg))
    else $error("clamp did not drive outputs from the latch");
  chk_highz_pins: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    ir_reg == IR_HIGHZ [*2] |=> !PIN_OUT_EN)
    else $error("highz did not float outputs");

endmodule : bst_tap
`default_nettype wire

// >>> sim/bst_host.sv
`default_nettype none
module bst_host (
  input  wire logic clk,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Frames
  // ----------------------------------------
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    trst_n = 1'b1;
  end

  // The clock rests low between frames. Edges sit off the system clock grid on purpose.
  task automatic frame(input logic [63:0] m, input logic [63:0] d, input int n,
                       output logic [63:0] q);
    q = '0;
    @(negedge clk);
    #0.3;
    for (int i = 0; i < n; i++) begin
      tms = m[i];
      tdi = d[i];
      #32 q[i] = tdo;
      tck = 1'b1;
      #32 tck = 1'b0;
    end
    // A released data line must not keep looking valid.
    tdi = ~tdi;
  endtask : frame

  task automatic pulse_reset();
    @(negedge clk);
    trst_n = 1'b0;
    repeat (6) @(negedge clk);
    trst_n = 1'b1;
  endtask : pulse_reset
endmodule : bst_host
`default_nettype wire

// >>> sim/test_boundary_scan_tap_controller.sv
`default_nettype none
module test_boundary_scan_tap_controller
  import bst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Fixture
  // ----------------------------------------
  localparam logic [10:0] MFR  = 11'h2a5;  // Arbitrary value.
  localparam logic [15:0] PART = 16'h5a3c; // Arbitrary value.
  localparam logic [3:0]  VER  = 4'h9;     // Arbitrary value.
  localparam logic [31:0] ID   = {VER, PART, MFR, 1'b1};
  localparam logic [45:0] SAMP = 46'h2a5a_1234_5678;
  localparam logic [45:0] CORE = 46'h0f0f_0f0f_0f0f;
  localparam logic [45:0] P1   = 46'h1111_2222_3333;
  localparam logic [45:0] P2   = 46'h3c3c_a5a5_0f0f;

  typedef struct packed {
    logic [2:0]  code;
    logic [6:0]  n;
    logic [63:0] din;
    logic [63:0] dout;
    logic [45:0] pin;
    logic        oe;
  } bst_row_s;

  // Bypass rows expect the input one stage late behind a captured zero.
  localparam bst_row_s ROWS [6] = '{
    '{IR_SAMPLE, 7'd46, 64'(P1), 64'(SAMP), CORE, 1'b1},
    '{IR_EXTEST, 7'd46, 64'(P2), 64'(SAMP), P2, 1'b1},
    '{IR_CLAMP,  7'd8,  64'ha5,  64'h4a,    P2, 1'b1},
    '{IR_HIGHZ,  7'd8,  64'h3c,  64'h78,    CORE, 1'b0},
    '{IR_BYPASS, 7'd8,  64'hc3,  64'h86,    CORE, 1'b1},
    '{IR_IDCODE, 7'd32, 64'h0,   64'(ID),   CORE, 1'b1}
  };

  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        tck, tms, tdi, trst_n;
  logic        tdo_out, tdo_oe, tdo_w, pin_en;
  logic [45:0] pin_out;
  logic [2:0]  cur_instr;
  logic [3:0]  tap_state;
  logic [63:0] q;
  int          n_fail  = 0;
  int          n_tests = 0;

  always #2.5 clk_sys = ~clk_sys;

  // A released serial out reads high, as through a pull-up.
  assign tdo_w = tdo_oe ? tdo_out : 1'b1;

  bst_tap #(.MFR_CODE(MFR), .PART_ID(PART), .VERSION(VER)) dut_u (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .TEST_PORT_RESET_N(trst_n),
    .TEST_PORT_CLOCK(tck), .TEST_PORT_MODE_SELECT(tms), .TEST_PORT_SERIAL_IN(tdi),
    .TEST_PORT_SERIAL_OUT(tdo_out), .TEST_PORT_SERIAL_OE(tdo_oe),
    .PIN_SAMPLE(SAMP), .CORE_OUT(CORE), .PIN_OUT(pin_out), .PIN_OUT_EN(pin_en),
    .CUR_INSTR(cur_instr), .TAP_STATE(tap_state));

  bst_host host_u (.clk(clk_sys), .tdo(tdo_w), .tck(tck), .tms(tms), .tdi(tdi),
                   .trst_n(trst_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic load_ir(input logic [2:0] code);
    host_u.frame(64'h0c3, {57'h0, code, 4'h0}, 9, q);
    chk("ir_capture", q[6:4], IR_CAPTURE);
    chk("cur_instr", cur_instr, code);
  endtask : load_ir

  task automatic scan_dr(input logic [63:0] din, input int n);
    host_u.frame(64'h1 | (64'h3 << (n + 2)), din << 3, n + 5, q);
    q = (q >> 3) & ((64'h1 << n) - 64'h1);
  endtask : scan_dr

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("reset_state", tap_state, ST_RESET);
    chk("reset_instr", cur_instr, IR_IDCODE);
    chk("reset_pins", pin_out, CORE);
    chk("reset_en", pin_en, 1'b1);
    host_u.frame(64'h0, 64'h0, 2, q);
    chk("idle_state", tap_state, ST_IDLE);
    foreach (ROWS[i]) begin
      load_ir(ROWS[i].code);
      scan_dr(ROWS[i].din, int'(ROWS[i].n));
      chk("dr_out", q, ROWS[i].dout);
      chk("pin_out", pin_out, ROWS[i].pin);
      chk("pin_en", pin_en, ROWS[i].oe);
      chk("tdo_oe", tdo_oe, 1'b0);
    end
    host_u.frame(64'h40001, 64'h0, 21, q);
    chk("id_low", q[18:3], ID[15:0]);
    chk("pause_dr", tap_state, ST_PAUSE_DR);
    host_u.frame(64'h60001, 64'h0, 20, q);
    chk("id_high", q[17:2], ID[31:16]);
    chk("idle_dr", tap_state, ST_IDLE);
    host_u.frame(64'h6a3, 64'h200, 12, q);
    chk("ir_pause_cap", {q[9], q[5], q[4]}, IR_CAPTURE);
    chk("ir_pause_ins", cur_instr, IR_HIGHZ);
    chk("highz_en", pin_en, 1'b0);
    host_u.frame(64'h1b, 64'h0, 6, q);
    chk("cap_exit_ins", cur_instr, IR_CAPTURE);
    chk("cap_exit_en", pin_en, 1'b1);
    load_ir(IR_BYPASS);
    host_u.frame(64'h7d, 64'h0, 7, q);
    chk("tms_reset", tap_state, ST_RESET);
    chk("tms_reset_ins", cur_instr, IR_IDCODE);
    host_u.frame(64'h0, 64'h0, 1, q);
    load_ir(IR_BYPASS);
    host_u.pulse_reset();
    repeat (4) @(negedge clk_sys);
    chk("trst_state", tap_state, ST_RESET);
    chk("trst_ins", cur_instr, IR_IDCODE);
    stop_test();
  end

  // The whole sequence needs about 20 us of test clock frames.
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule : test_boundary_scan_tap_controller
`default_nettype wire
